/* File: rtl/ubm_ctrl.sv */
// Purpose: device-side bus mode control of a low pin count transceiver link
// Assumes: link clock and stop pin sampled by clock_i through three flops
// Notes:   synchronous steps advance on sampled rising link clock edges
`timescale 1ns/1ps
`default_nettype none
module ubm_ctrl #(
  parameter int WIDTH = ubm_pkg::DATA_W,
  parameter int DEPTH = ubm_pkg::FIFO_DEPTH
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             link_clock_i,
  input  wire logic             stop_i,
  input  wire logic [WIDTH-1:0] data_in_i,
  output var  logic [WIDTH-1:0] data_out_o,
  output var  logic [WIDTH-1:0] data_oe_n_o,
  output var  logic             direction_o,
  output var  logic             next_o,
  output var  logic             clock_enable_o,
  input  wire logic             suspend_write_i,
  input  wire logic             active_low_suspend_bit_i,
  input  wire logic             serial_write_i,
  input  wire logic             six_wire_serial_select_i,
  input  wire logic             keep_clock_running_bit_i,
  input  wire logic             ddr4_mode_i,
  output var  logic             active_low_suspend_bit_o,
  output var  logic             six_wire_serial_select_o,
  input  wire logic [WIDTH-1:0] rx_data_i,
  input  wire logic             rx_valid_i,
  output var  logic             rx_ready_o,
  input  wire logic [WIDTH-1:0] rx_status_i,
  input  wire logic             status_req_i,
  input  wire logic [WIDTH-1:0] read_data_i,
  input  wire logic             read_req_i,
  output var  logic             read_done_o,
  input  wire logic             tx_ready_i,
  output var  logic [WIDTH-1:0] tx_data_o,
  output var  logic             tx_valid_o,
  input  wire logic [1:0]       line_state_i,
  input  wire logic             int_event_i,
  input  wire logic             int_pending_i,
  input  wire logic             rx_dp_i,
  input  wire logic             rx_dm_i,
  input  wire logic             rx_diff_i,
  output var  logic             s6_tx_enable_o,
  output var  logic             s6_tx_data_o,
  output var  logic             s6_tx_se0_o
);
  initial
  begin
    if (WIDTH != 8)
      $error("data bus must be 8 bits");
  end

  ubm_pkg::ubm_state_t state;
  ubm_pkg::ubm_state_t next_state;
  logic [2:0]       lclk_sync;
  logic [2:0]       stop_sync;
  logic             lclk_level;
  logic             stop_level;
  logic             tick;
  logic             int_latch;
  logic             after_wake;
  logic [WIDTH-1:0] fifo_data;
  logic             fifo_valid;
  logic             fifo_pop;
  logic             ifc_idle;
  logic [2:0]       s6_sync [3];
  logic [2:0]       s6_level;

  // three-stage sampling of outside signals; a change counts when 2 and 3 agree
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      lclk_sync  <= '0;
      stop_sync  <= '0;
      lclk_level <= 1'b0;
      stop_level <= 1'b0;
    end
    else
    begin
      lclk_sync <= {lclk_sync[1:0], link_clock_i};
      stop_sync <= {stop_sync[1:0], stop_i};
      if (lclk_sync[1] == lclk_sync[2])
        lclk_level <= lclk_sync[2];
      if (stop_sync[1] == stop_sync[2])
        stop_level <= stop_sync[2];
    end
  end

  assign tick = (lclk_sync[1] == lclk_sync[2]) && lclk_sync[2] && !lclk_level;

  // three-stage sampling of the six-wire transmit pins, bitwise agreement
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s6_sync[0] <= '0;
      s6_sync[1] <= '0;
      s6_sync[2] <= '0;
      s6_level   <= '0;
    end
    else
    begin
      s6_sync[0] <= data_in_i[2:0];
      s6_sync[1] <= s6_sync[0];
      s6_sync[2] <= s6_sync[1];
      s6_level   <= (s6_sync[1] & s6_sync[2]) | (s6_level & (s6_sync[1] | s6_sync[2]));
    end
  end

  ubm_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .in_data_i   (rx_data_i),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  assign ifc_idle = !fifo_valid && !status_req_i && !read_req_i;

  // mode sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      ubm_pkg::UBM_SYNC_IDLE:
        if (!active_low_suspend_bit_o && ifc_idle)
          next_state = ubm_pkg::UBM_SYNC_TURN_OUT;
        else if (six_wire_serial_select_o && ifc_idle)
          next_state = ubm_pkg::UBM_SYNC_TURN_OUT;
        else if (fifo_valid || status_req_i || read_req_i)
          next_state = ubm_pkg::UBM_SYNC_TURN_OUT;
      ubm_pkg::UBM_SYNC_TURN_OUT:
        if (!active_low_suspend_bit_o && ifc_idle)
          next_state = ubm_pkg::UBM_LOW_POWER;
        else if (six_wire_serial_select_o && ifc_idle)
          next_state = ubm_pkg::UBM_SERIAL6;
        else
          next_state = ubm_pkg::UBM_SYNC_SEND;
      ubm_pkg::UBM_SYNC_SEND:
        if (stop_level || (!fifo_valid && !read_req_i && !status_req_i))
          next_state = ubm_pkg::UBM_SYNC_TURN_IN;
      ubm_pkg::UBM_SYNC_TURN_IN:
        next_state = ubm_pkg::UBM_SYNC_IDLE;
      ubm_pkg::UBM_LOW_POWER,
      ubm_pkg::UBM_SERIAL6:
        if (stop_level)
          next_state = ubm_pkg::UBM_WAKE_TURN;
      ubm_pkg::UBM_WAKE_TURN:
        if (!stop_level)
          next_state = (after_wake && int_pending_i) ? ubm_pkg::UBM_WAKE_STATUS
                                                     : ubm_pkg::UBM_SYNC_TURN_IN;
      ubm_pkg::UBM_WAKE_STATUS:
        next_state = ubm_pkg::UBM_SYNC_TURN_IN;
      default:
        next_state = ubm_pkg::UBM_SYNC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= ubm_pkg::UBM_SYNC_IDLE;
    else if (tick)
      state <= next_state;
  end

  // mode control bits, wake restores defaults
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      active_low_suspend_bit_o <= ubm_pkg::SUSPEND_RESET;
      six_wire_serial_select_o <= ubm_pkg::SERIAL6_RESET;
    end
    else if (tick && state == ubm_pkg::UBM_WAKE_TURN && !stop_level)
    begin
      active_low_suspend_bit_o <= 1'b1;
      six_wire_serial_select_o <= 1'b0;
    end
    else
    begin
      if (suspend_write_i)
        active_low_suspend_bit_o <= active_low_suspend_bit_i;
      if (serial_write_i)
        six_wire_serial_select_o <= six_wire_serial_select_i && !ddr4_mode_i;
    end
  end

  // interrupt latch and wake memory
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      int_latch  <= 1'b0;
      after_wake <= 1'b0;
    end
    else
    begin
      if (state == ubm_pkg::UBM_LOW_POWER || state == ubm_pkg::UBM_SERIAL6)
      begin
        if (int_event_i)
          int_latch <= 1'b1;
        after_wake <= 1'b1;
      end
      else if (tick && state == ubm_pkg::UBM_SYNC_TURN_IN)
      begin
        int_latch  <= 1'b0;
        after_wake <= 1'b0;
      end
    end
  end

  assign fifo_pop = tick && state == ubm_pkg::UBM_SYNC_SEND && !read_req_i && fifo_valid;

  // direction, next and data bus
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      direction_o    <= 1'b0;
      next_o         <= 1'b0;
      data_out_o     <= ubm_pkg::DATA_IDLE;
      data_oe_n_o    <= ubm_pkg::DATA_OE_NONE;
      read_done_o    <= 1'b0;
      tx_data_o      <= '0;
      tx_valid_o     <= 1'b0;
      clock_enable_o <= 1'b1;
    end
    else
    begin
      read_done_o    <= 1'b0;
      tx_valid_o     <= 1'b0;
      next_o         <= 1'b0;
      data_oe_n_o    <= ubm_pkg::DATA_OE_NONE;
      data_out_o     <= ubm_pkg::DATA_IDLE;
      clock_enable_o <= 1'b1;
      direction_o    <= state != ubm_pkg::UBM_SYNC_IDLE &&
                        state != ubm_pkg::UBM_SYNC_TURN_IN;
      case (state)
        ubm_pkg::UBM_SYNC_IDLE:
        begin
          // link bytes accepted one per link clock with next high
          next_o <= tx_ready_i && data_in_i != ubm_pkg::DATA_IDLE;
          if (tick && next_o && !stop_level)
          begin
            tx_data_o  <= data_in_i;
            tx_valid_o <= 1'b1;
          end
        end
        ubm_pkg::UBM_SYNC_SEND:
        begin
          data_oe_n_o <= ubm_pkg::DATA_OE_ALL;
          if (read_req_i)
          begin
            data_out_o  <= read_data_i;
            read_done_o <= tick;
          end
          else if (fifo_valid)
          begin
            data_out_o <= fifo_data;
            next_o     <= 1'b1;
          end
          else
            data_out_o <= rx_status_i;
        end
        ubm_pkg::UBM_WAKE_STATUS:
        begin
          data_oe_n_o <= ubm_pkg::DATA_OE_ALL;
          data_out_o  <= rx_status_i;
        end
        ubm_pkg::UBM_LOW_POWER:
        begin
          data_oe_n_o                      <= ubm_pkg::DATA_OE_LP;
          data_out_o[ubm_pkg::LP_LS0_BIT]  <= line_state_i[0];
          data_out_o[ubm_pkg::LP_LS1_BIT]  <= line_state_i[1];
          data_out_o[ubm_pkg::INT_BIT]     <= int_latch || int_event_i;
          clock_enable_o                   <= keep_clock_running_bit_i;
        end
        ubm_pkg::UBM_SERIAL6:
        begin
          data_oe_n_o                      <= ubm_pkg::DATA_OE_S6;
          data_out_o[ubm_pkg::INT_BIT]     <= int_latch || int_event_i;
          data_out_o[ubm_pkg::S6_RXDP_BIT] <= rx_dp_i;
          data_out_o[ubm_pkg::S6_RXDM_BIT] <= rx_dm_i;
          data_out_o[ubm_pkg::S6_RXDIF_BIT] <= rx_diff_i;
          clock_enable_o                   <= keep_clock_running_bit_i;
        end
        default:
        begin
        end
      endcase
    end
  end

  // six-wire transmit controls taken from the link's pins
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s6_tx_enable_o <= 1'b0;
      s6_tx_data_o   <= 1'b0;
      s6_tx_se0_o    <= 1'b0;
    end
    else if (state == ubm_pkg::UBM_SERIAL6)
    begin
      s6_tx_enable_o <= s6_level[ubm_pkg::S6_TXEN_BIT];
      s6_tx_data_o   <= s6_level[ubm_pkg::S6_TXDAT_BIT];
      s6_tx_se0_o    <= s6_level[ubm_pkg::S6_TXSE0_BIT];
    end
    else
    begin
      s6_tx_enable_o <= 1'b0;
      s6_tx_data_o   <= 1'b0;
      s6_tx_se0_o    <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/ubm_pkg.sv */
// Purpose: shared constants for the link bus mode controller
// Assumes: block clock 50 MHz
// Notes:   mode codes and data bus field positions
package ubm_pkg;
  typedef enum logic [2:0] {
    UBM_SYNC_IDLE,
    UBM_SYNC_TURN_OUT,
    UBM_SYNC_SEND,
    UBM_SYNC_TURN_IN,
    UBM_LOW_POWER,
    UBM_SERIAL6,
    UBM_WAKE_TURN,
    UBM_WAKE_STATUS
  } ubm_state_t;

  localparam int          CLK_MHZ          = 50;
  localparam int          DATA_W           = 8;
  localparam int          FIFO_DEPTH       = 32;
  localparam logic        SUSPEND_RESET    = 1'b1;
  localparam logic        SERIAL6_RESET    = 1'b0;
  localparam logic        KEEPCLK_RESET    = 1'b0;
  localparam int          LP_LS0_BIT       = 0;
  localparam int          LP_LS1_BIT       = 1;
  localparam int          INT_BIT          = 3;
  localparam int          S6_TXEN_BIT      = 0;
  localparam int          S6_TXDAT_BIT     = 1;
  localparam int          S6_TXSE0_BIT     = 2;
  localparam int          S6_RXDP_BIT      = 4;
  localparam int          S6_RXDM_BIT      = 5;
  localparam int          S6_RXDIF_BIT     = 6;
  localparam logic [7:0]  DATA_IDLE        = 8'h00;
  localparam logic [7:0]  DATA_OE_NONE     = 8'hFF;
  localparam logic [7:0]  DATA_OE_ALL      = 8'h00;
  localparam logic [7:0]  DATA_OE_LP       = 8'h00;
  localparam logic [7:0]  DATA_OE_S6       = 8'h07;
endpackage

/* File: rtl/ubm_fifo.sv */
// Purpose: receive byte buffer with valid/ready on both sides
// Assumes: one clock domain
// Notes:   depth must be a power of two
`timescale 1ns/1ps
`default_nettype none
module ubm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  output var  logic [WIDTH-1:0] out_data_o,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock_i)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_i;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verif/ubm_checker.sv */
// Purpose: port-level checks for the bus mode controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound into every ubm_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module ubm_checker (
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic       direction_o,
  input wire logic       next_o,
  input wire logic [7:0] data_out_o,
  input wire logic [7:0] data_oe_n_o,
  input wire logic       ddr4_mode_i,
  input wire logic       serial_write_i,
  input wire logic       active_low_suspend_bit_o,
  input wire logic       six_wire_serial_select_o,
  input wire logic       read_done_o,
  input wire logic       tx_valid_o
);
  logic lp_map;
  assign lp_map = !active_low_suspend_bit_o && direction_o && data_oe_n_o == 8'h00;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  a_listen_released: assert property (!direction_o |-> data_oe_n_o == 8'hFF)
    else $error("bus driven while direction low");
  a_turn_quiet: assert property ($changed(direction_o) |-> !next_o && data_oe_n_o == 8'hFF)
    else $error("bus driven in turnaround");
  a_lp_reserved_low: assert property (lp_map |-> !data_out_o[2] && data_out_o[7:4] == 4'h0)
    else $error("low power reserved bits high");
  a_s6_top_low: assert property (six_wire_serial_select_o && data_oe_n_o == 8'h07 |-> !data_out_o[7])
    else $error("six wire bit 7 high");
  a_ddr_refused: assert property (ddr4_mode_i && serial_write_i && !six_wire_serial_select_o
    |=> !six_wire_serial_select_o)
    else $error("six wire taken in double rate");
  a_drop_in_sync: assert property ($fell(direction_o)
    |-> active_low_suspend_bit_o && !six_wire_serial_select_o)
    else $error("direction dropped outside sync mode");
  a_read_owns_bus: assert property (read_done_o |-> direction_o)
    else $error("read data without direction");
  a_accept_listen: assert property (tx_valid_o |-> !direction_o ##1 !tx_valid_o)
    else $error("link byte taken while sending");
  c_low_power: cover property (lp_map);
  c_six_wire: cover property (data_oe_n_o == 8'h07);
  c_read: cover property (read_done_o);
  c_link_byte: cover property (tx_valid_o);
endmodule
bind ubm_ctrl ubm_checker u_chk (.*);
`default_nettype wire

/* File: verif/ubm_link_model.sv */
// Purpose: behavioural link controller facing the bus mode controller
// Assumes: interface clock stands still while the device turns it off
// Notes:   one-byte transmit commands, stop level for wake
`timescale 1ns/1ps
`default_nettype none
module ubm_link_model (
  input  wire logic       clock_enable_i,
  input  wire logic       direction_i,
  input  wire logic       next_i,
  input  wire logic       send_i,
  input  wire logic [7:0] cmd_i,
  input  wire logic       stop_req_i,
  input  wire logic       wake_clock_i,
  input  wire logic       s6_i,
  input  wire logic [2:0] s6_bits_i,
  output var  logic       link_clock_o,
  output var  logic       stop_o,
  output var  logic [7:0] link_data_o,
  output var  logic [7:0] link_oe_o
);
  logic       busy = 1'b0;
  logic       end_pulse = 1'b0;
  logic [7:0] byte_q = 8'h00;
  initial
  begin
    link_clock_o = 1'b0;
    #7;
    forever
    begin
      #80;
      if (clock_enable_i || wake_clock_i || link_clock_o)
        link_clock_o = ~link_clock_o;
    end
  end
  always @(negedge link_clock_o)
  begin
    end_pulse <= 1'b0;
    if (busy && next_i)
    begin
      busy      <= 1'b0;
      byte_q    <= 8'h00;
      end_pulse <= 1'b1;
    end
    else if (send_i && !busy && !direction_i)
    begin
      busy   <= 1'b1;
      byte_q <= cmd_i;
    end
  end
  assign stop_o      = stop_req_i || end_pulse;
  assign link_data_o = direction_i ? {5'h00, s6_bits_i} : byte_q;
  assign link_oe_o   = !direction_i ? 8'hFF : (s6_i ? 8'h07 : 8'h00);
endmodule
`default_nettype wire

/* File: verif/ubm_ctrl_tb_top.sv */
// Purpose: self-checking bench for the bus mode controller
// Assumes: 50 MHz block clock, link clock from the link model
// Notes:   seeded random data with corner cases
`timescale 1ns/1ps
`default_nettype none
module ubm_ctrl_tb_top;
  logic       clock_i = 1'b0, reset_n_i = 1'b0, suspend_write_i = 1'b0;
  logic       active_low_suspend_bit_i = 1'b1, serial_write_i = 1'b0;
  logic       six_wire_serial_select_i = 1'b0, keep_clock_running_bit_i = 1'b0;
  logic       ddr4_mode_i = 1'b0, rx_valid_i = 1'b0, status_req_i = 1'b0;
  logic       read_req_i = 1'b0, tx_ready_i = 1'b1, int_event_i = 1'b0;
  logic       int_pending_i = 1'b0, rx_dp_i = 1'b0, rx_dm_i = 1'b0, rx_diff_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00, rx_status_i = 8'h00, read_data_i = 8'h00;
  logic [1:0] line_state_i = 2'h0;
  wire  logic link_clock_i, stop_i;
  wire  logic [7:0] data_in_i, link_data, link_oe;
  logic [7:0] data_out_o, data_oe_n_o, tx_data_o, bus_last = 8'h00, cmd = 8'h00;
  logic       direction_o, next_o, clock_enable_o, active_low_suspend_bit_o;
  logic       six_wire_serial_select_o, rx_ready_o, read_done_o, tx_valid_o;
  logic       s6_tx_enable_o, s6_tx_data_o, s6_tx_se0_o, send = 1'b0, stop_req = 1'b0;
  logic       wake_clk = 1'b0, s6_on = 1'b0, seen_rd = 1'b0, rx_watch = 1'b0;
  logic [2:0] s6_bits = 3'h0;
  logic [7:0] exp_q[$];
  int         errors = 0, checked = 0, cycles = 0, i, k;

  ubm_ctrl u_dut (.*);
  ubm_link_model u_link (.clock_enable_i(clock_enable_o), .direction_i(direction_o),
    .next_i(next_o), .send_i(send), .cmd_i(cmd), .stop_req_i(stop_req),
    .wake_clock_i(wake_clk), .s6_i(s6_on), .s6_bits_i(s6_bits),
    .link_clock_o(link_clock_i), .stop_o(stop_i), .link_data_o(link_data),
    .link_oe_o(link_oe));
  // released bits show the inverse of the last level
  assign data_in_i = (~data_oe_n_o & data_out_o) | (data_oe_n_o & link_oe & link_data)
                   | (data_oe_n_o & ~link_oe & ~bus_last);
  always @(posedge clock_i) bus_last <= data_in_i;
  always @(posedge link_clock_i)
    if (read_req_i && direction_o && !next_o && data_oe_n_o == 8'h00
        && data_out_o === read_data_i)
      seen_rd <= 1'b1;
  always @(posedge link_clock_i)
    if (rx_watch && direction_o === 1'b1 && next_o === 1'b1)
      chk(exp_q.size() > 0 && data_out_o === exp_q.pop_front(), "rx byte");
    else if (rx_watch && direction_o === 1'b1 && data_oe_n_o === 8'h00)
      chk(data_out_o === rx_status_i, "status byte");
  initial
  begin
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  function automatic logic [7:0] lp_exp(input logic [1:0] ls, input logic irq);
    return {4'h0, irq, 1'b0, ls};
  endfunction
  function automatic logic [4:0] s6_exp(input logic dp, input logic dm, input logic df);
    return {1'b0, df, dm, dp, 1'b0};
  endfunction
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic wait_idle();
    for (i = 0; i < 300 && direction_o !== 1'b0; i++) @(negedge clock_i);
  endtask
  task automatic wake();
    wake_clk = 1'b1;
    stop_req = 1'b1;
    tick(32);
    stop_req = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    void'($urandom(55890));
    tick(8);
    reset_n_i = 1'b1;
    tick(6);
    chk(direction_o === 1'b0 && data_oe_n_o === 8'hFF, "reset bus");
    chk(active_low_suspend_bit_o === 1'b1 && six_wire_serial_select_o === 1'b0, "bits");
    $display("reset test done");
    rx_status_i = 8'($urandom);
    rx_watch = 1'b1;
    rx_valid_i = 1'b1;
    rx_data_i = 8'h00;
    for (i = 0; i < 80 && rx_ready_o === 1'b1; i++)
    begin
      exp_q.push_back(rx_data_i);
      @(negedge clock_i);
      rx_data_i = 8'($urandom);
    end
    chk(i >= 32 && rx_ready_o === 1'b0, "buffer refuse");
    rx_valid_i = 1'b0;
    for (k = 0; k < 400 && (exp_q.size() > 0 || direction_o === 1'b1); k++)
      @(posedge link_clock_i);
    rx_watch = 1'b0;
    chk(exp_q.size() == 0 && direction_o === 1'b0, "rx drained");
    $display("receive test done");
    read_data_i = rx_status_i ^ 8'($urandom_range(1, 255));
    read_req_i = 1'b1;
    for (i = 0; i < 200 && read_done_o !== 1'b1; i++) @(negedge clock_i);
    read_req_i = 1'b0;
    chk(seen_rd, "read data");
    wait_idle();
    status_req_i = 1'b1;
    for (i = 0; i < 200 && !(direction_o && data_oe_n_o == 8'h00); i++) tick(1);
    chk(data_out_o === rx_status_i && next_o === 1'b0, "status request");
    stop_req = 1'b1;
    for (i = 0; i < 40 && direction_o !== 1'b0; i++) tick(1);
    chk(direction_o === 1'b0 && i < 40, "stop release");
    status_req_i = 1'b0;
    stop_req = 1'b0;
    wait_idle();
    $display("read test done");
    tx_ready_i = 1'b0;
    cmd = 8'hFF;
    send = 1'b1;
    tick(40);
    chk(next_o === 1'b0 && tx_valid_o === 1'b0, "throttle");
    tx_ready_i = 1'b1;
    for (k = 0; k < 3; k++)
    begin
      cmd = (k == 0) ? 8'hFF : 8'($urandom_range(1, 255));
      send = 1'b1;
      for (i = 0; i < 200 && tx_valid_o !== 1'b1; i++) @(negedge clock_i);
      chk(tx_valid_o === 1'b1 && tx_data_o === cmd, "link byte");
      send = 1'b0;
      tick(40);
    end
    $display("transmit test done");
    int_pending_i = 1'b1;
    active_low_suspend_bit_i = 1'b0;
    suspend_write_i = 1'b1;
    tick(1);
    suspend_write_i = 1'b0;
    for (i = 0; i < 200 && !(direction_o && data_oe_n_o == 8'h00); i++) tick(1);
    line_state_i = 2'($urandom);
    tick(3);
    chk(data_out_o === lp_exp(line_state_i, 1'b0), "low power map");
    chk(clock_enable_o === 1'b0, "clock off");
    int_event_i = 1'b1;
    tick(1);
    int_event_i = 1'b0;
    tick(3);
    chk(data_out_o === lp_exp(line_state_i, 1'b1) && direction_o === 1'b1, "irq");
    wake();
    for (i = 0; i < 200 && !(active_low_suspend_bit_o && data_oe_n_o == 8'h00); i++) tick(1);
    chk(direction_o === 1'b1 && data_out_o === rx_status_i, "wake status");
    int_pending_i = 1'b0;
    wait_idle();
    wake_clk = 1'b0;
    chk(direction_o === 1'b0, "back in sync");
    $display("low power test done");
    ddr4_mode_i = 1'b1;
    six_wire_serial_select_i = 1'b1;
    serial_write_i = 1'b1;
    tick(1);
    serial_write_i = 1'b0;
    tick(2);
    chk(six_wire_serial_select_o === 1'b0, "double rate refuse");
    ddr4_mode_i = 1'b0;
    keep_clock_running_bit_i = 1'b1;
    s6_on = 1'b1;
    serial_write_i = 1'b1;
    tick(1);
    serial_write_i = 1'b0;
    for (i = 0; i < 200 && !(direction_o && data_oe_n_o == 8'h07); i++) tick(1);
    for (k = 0; k < 4; k++)
    begin
      {rx_dp_i, rx_dm_i, rx_diff_i, s6_bits} = 6'($urandom);
      tick(6);
      chk({s6_tx_se0_o, s6_tx_data_o, s6_tx_enable_o} === s6_bits, "s6 tx");
      chk(data_out_o[7:3] === s6_exp(rx_dp_i, rx_dm_i, rx_diff_i), "s6 rx");
      chk(clock_enable_o === 1'b1, "clock kept");
    end
    wake();
    wait_idle();
    s6_on = 1'b0;
    wake_clk = 1'b0;
    chk(six_wire_serial_select_o === 1'b0 && active_low_suspend_bit_o === 1'b1, "s6 exit");
    $display("serial test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
